/* rtl/normal_xform_texcoord_gen.sv */
`timescale 1ns/1ns
module normal_xform_texcoord_gen
  import xform_gen_pkg::*;
#(
  parameter int NUM_UNITS = 2,
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // inverse model-view matrix from the matrix stage
  input wire mat4_t mv_inv,
  // incoming vertex
  input wire logic vin_valid,
  output logic vin_ready,
  input wire vertex_in_t vin,
  input wire vec4_t [NUM_UNITS-1:0] vin_tex,
  // results toward lighting and the texture matrix stage
  output logic vout_valid,
  input wire logic vout_ready,
  output vec3_t vout_normal,
  output vec4_t [NUM_UNITS-1:0] vout_tex
);

  localparam int COORD_SET_LIMIT = NUM_UNITS;

  typedef struct packed {
    logic rescale_en;
    logic unit_len_en;
    logic [2:0] active_unit;
    vec4_t staging;
    logic err_enum;
    logic err_op;
    logic [NUM_UNITS-1:0][3:0] gen_en;
    gen_func_t [NUM_UNITS-1:0][3:0] func;
    vec4_t [NUM_UNITS-1:0][3:0] obj_plane;
    vec4_t [NUM_UNITS-1:0][3:0] eye_plane;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    fsm_t fsm;
    vertex_in_t vtx;
    vec4_t [NUM_UNITS-1:0] tex_in;
    vec3_t nrm;
    vec3_t refl;
    vec4_t [NUM_UNITS-1:0] tex_out;
  } state_t;

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  // products wrap instead of saturating; garbage in, garbage out, never a stall
  function automatic fx_t fx_mul(fx_t a, fx_t b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return p[FX_FRAC+31:FX_FRAC];
  endfunction : fx_mul

  function automatic fx_t fx_dot3(vec3_t a, vec3_t b);
    return fx_mul(a[0], b[0]) + fx_mul(a[1], b[1]) + fx_mul(a[2], b[2]);
  endfunction : fx_dot3

  function automatic fx_t fx_dot4(vec4_t a, vec4_t b);
    return fx_mul(a[0], b[0]) + fx_mul(a[1], b[1]) + fx_mul(a[2], b[2])
      + fx_mul(a[3], b[3]);
  endfunction : fx_dot4

  // zero or negative input yields zero: a zero-length vector stays zero
  function automatic fx_t fx_rsqrt(fx_t x);
    logic [63:0] v;
    logic [63:0] t;
    logic [63:0] root;
    logic [63:0] q;
    v = 64'h0;
    t = 64'h0;
    root = 64'h0;
    q = 64'h0;
    if (x > FX_ZERO) begin
      v = {16'h0, x, 16'h0};
      for (int b = 31; b >= 0; b--) begin
        t = root | (64'h1 << b);
        if (t * t <= v) begin
          root = t;
        end
      end
      q = FX_RECIP_NUM / root;
      if (q > FX_SAT) begin
        q = FX_SAT;
      end
    end
    return q[31:0];
  endfunction : fx_rsqrt

  function automatic vec3_t vec_scale(vec3_t a, fx_t f);
    vec3_t r;
    for (int k = 0; k < 3; k++) begin
      r[k] = fx_mul(a[k], f);
    end
    return r;
  endfunction : vec_scale

  function automatic logic [31:0] apply_strb(logic [31:0] old, logic [31:0] nw,
                                             logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  function automatic logic [7:0] word_addr(logic [ADDR_W-1:0] a);
    return {a[7:2], 2'b00};
  endfunction : word_addr

  function automatic state_t reset_value();
    state_t r;
    r = '0;
    r.fsm = ST_IDLE;
    for (int u = 0; u < NUM_UNITS; u++) begin
      for (int c = 0; c < 4; c++) begin
        r.func[u][c] = GEN_EYE_LINEAR;
      end
      r.obj_plane[u][COORD_S][0] = FX_ONE;
      r.obj_plane[u][COORD_T][1] = FX_ONE;
      r.eye_plane[u][COORD_S][0] = FX_ONE;
      r.eye_plane[u][COORD_T][1] = FX_ONE;
    end
    return r;
  endfunction : reset_value

  localparam state_t RESET_STATE = reset_value();

  state_t state_reg;
  state_t state_next;

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  logic unit_ok;
  logic set_enum;
  logic set_op;
  logic clr_enum;
  logic clr_op;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [1:0] cmd_coord;
  logic [1:0] cmd_pname;
  logic [2:0] cmd_func;
  logic [7:0] ra;
  fx_t qterm;
  fx_t scale;
  fx_t ndotu;
  fx_t sph;
  vec3_t udir;
  vec3_t rz1;

  always_comb begin
    state_next = state_reg;
    set_enum = 1'b0;
    set_op = 1'b0;
    clr_enum = 1'b0;
    clr_op = 1'b0;
    unit_ok = 32'(state_reg.active_unit) < COORD_SET_LIMIT;
    wa = word_addr(state_reg.wr_addr);
    wd = state_reg.wr_data;
    cmd_coord = wd[CMD_COORD_LSB +: 2];
    cmd_pname = wd[CMD_PNAME_LSB +: 2];
    cmd_func = wd[CMD_FUNC_LSB +: FUNC_FIELD_W];
    ra = word_addr(araddr);
    qterm = FX_ZERO;
    scale = FX_ONE;
    ndotu = FX_ZERO;
    sph = FX_ZERO;
    udir = '0;
    rz1 = '0;

    // ---------------- register bus: write channel ----------------
    if (awvalid && awready) begin
      state_next.aw_held = 1'b1;
      state_next.wr_addr = awaddr;
    end
    if (wvalid && wready) begin
      state_next.w_held = 1'b1;
      state_next.wr_data = wdata;
      state_next.wr_strb = wstrb;
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = AXI_OKAY;
      case (wa)
        OFS_CTRL: begin
          if (state_reg.wr_strb[0]) begin
            state_next.rescale_en = wd[CTRL_RESCALE_BIT];
            state_next.unit_len_en = wd[CTRL_UNIT_LEN_BIT];
          end
        end
        OFS_ACTIVE_UNIT: begin
          if (state_reg.wr_strb[0]) begin
            state_next.active_unit = wd[2:0];
          end
        end
        OFS_GEN_ENABLE: begin
          if (!unit_ok) begin
            set_op = 1'b1;
          end else if (state_reg.wr_strb[0]) begin
            state_next.gen_en[state_reg.active_unit] = wd[3:0];
          end
        end
        OFS_PLANE0, OFS_PLANE1, OFS_PLANE2, OFS_PLANE3: begin
          state_next.staging[wa[3:2] - 2'h3] =
            apply_strb(state_reg.staging[wa[3:2] - 2'h3], wd, state_reg.wr_strb);
        end
        OFS_SETUP_CMD: begin
          // every rejection below leaves the stored state alone
          if (!unit_ok) begin
            set_op = 1'b1;
          end else if (cmd_pname == PNAME_FUNC) begin
            if (cmd_func > 3'(GEN_NORMAL)) begin
              set_enum = 1'b1;
            end else if (cmd_func == 3'(GEN_SPHERICAL_ENV) && cmd_coord >= COORD_R) begin
              set_enum = 1'b1;
            end else if ((cmd_func == 3'(GEN_REFLECTION) || cmd_func == 3'(GEN_NORMAL))
                         && cmd_coord == COORD_Q) begin
              set_enum = 1'b1;
            end else begin
              state_next.func[state_reg.active_unit][cmd_coord] =
                gen_func_t'(cmd_func);
            end
          end else if (cmd_pname == PNAME_OBJ_PLANE) begin
            state_next.obj_plane[state_reg.active_unit][cmd_coord] =
              state_reg.staging;
          end else if (cmd_pname == PNAME_EYE_PLANE) begin
            // matrix sampled now; later matrix changes do not touch it
            for (int j = 0; j < 4; j++) begin
              state_next.eye_plane[state_reg.active_unit][cmd_coord][j] =
                fx_dot4(state_reg.staging,
                        {mv_inv[3][j], mv_inv[2][j], mv_inv[1][j], mv_inv[0][j]});
            end
          end else begin
            set_enum = 1'b1;
          end
        end
        OFS_ERROR: begin
          clr_enum = state_reg.wr_strb[0] && wd[ERR_ENUM_BIT];
          clr_op = state_reg.wr_strb[0] && wd[ERR_OP_BIT];
        end
        OFS_FUNC_READ, OFS_STATUS: begin
        end
        default: begin
          state_next.bresp = AXI_SLVERR;
        end
      endcase
    end
    // a new error in the clearing cycle survives
    state_next.err_enum = (state_reg.err_enum && !clr_enum) || set_enum;
    state_next.err_op = (state_reg.err_op && !clr_op) || set_op;

    // ---------------- register bus: read channel ----------------
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = AXI_OKAY;
      state_next.rdata = 32'h0;
      case (ra)
        OFS_CTRL: begin
          state_next.rdata[CTRL_RESCALE_BIT] = state_reg.rescale_en;
          state_next.rdata[CTRL_UNIT_LEN_BIT] = state_reg.unit_len_en;
        end
        OFS_ACTIVE_UNIT: state_next.rdata[2:0] = state_reg.active_unit;
        OFS_GEN_ENABLE: begin
          if (unit_ok) begin
            state_next.rdata[3:0] = state_reg.gen_en[state_reg.active_unit];
          end
        end
        OFS_PLANE0, OFS_PLANE1, OFS_PLANE2, OFS_PLANE3: begin
          state_next.rdata = state_reg.staging[ra[3:2] - 2'h3];
        end
        OFS_SETUP_CMD: begin
        end
        OFS_ERROR: begin
          state_next.rdata[ERR_ENUM_BIT] = state_reg.err_enum;
          state_next.rdata[ERR_OP_BIT] = state_reg.err_op;
        end
        OFS_FUNC_READ: begin
          if (unit_ok) begin
            for (int c = 0; c < 4; c++) begin
              state_next.rdata[c*FUNC_FIELD_W +: FUNC_FIELD_W] =
                state_reg.func[state_reg.active_unit][c];
            end
          end
        end
        OFS_STATUS: state_next.rdata[0] = state_reg.fsm != ST_IDLE;
        default: state_next.rresp = AXI_SLVERR;
      endcase
    end

    // ---------------- vertex datapath ----------------
    // fixed number of steps per vertex, no data-dependent waits
    case (state_reg.fsm)
      ST_IDLE: begin
        if (vin_valid) begin
          state_next.vtx = vin;
          state_next.tex_in = vin_tex;
          state_next.fsm = ST_XFORM;
        end
      end
      ST_XFORM: begin
        // full four-term form kept rather than the 3x3 shortcut
        if (state_reg.vtx.obj[3] != FX_ZERO) begin
          qterm = -fx_dot3(state_reg.vtx.normal, state_reg.vtx.obj[2:0]);
        end
        for (int j = 0; j < 3; j++) begin
          state_next.nrm[j] = fx_dot4({qterm, state_reg.vtx.normal},
                                      {mv_inv[3][j], mv_inv[2][j], mv_inv[1][j],
                                       mv_inv[0][j]});
        end
        state_next.fsm = ST_RESCALE;
      end
      ST_RESCALE: begin
        // matrix-row factor chosen over per-normal length
        if (state_reg.rescale_en) begin
          scale = fx_rsqrt(fx_dot3(mv_inv[2][2:0], mv_inv[2][2:0]));
        end
        state_next.nrm = vec_scale(state_reg.nrm, scale);
        state_next.fsm = ST_NORM;
      end
      ST_NORM: begin
        if (state_reg.unit_len_en) begin
          scale = fx_rsqrt(fx_dot3(state_reg.nrm, state_reg.nrm));
        end
        state_next.nrm = vec_scale(state_reg.nrm, scale);
        state_next.fsm = ST_REFL;
      end
      ST_REFL: begin
        udir = vec_scale(state_reg.vtx.eye[2:0],
                         fx_rsqrt(fx_dot3(state_reg.vtx.eye[2:0],
                                          state_reg.vtx.eye[2:0])));
        ndotu = fx_dot3(state_reg.nrm, udir);
        for (int k = 0; k < 3; k++) begin
          state_next.refl[k] = udir[k] - (fx_mul(state_reg.nrm[k], ndotu) <<< 1);
        end
        state_next.fsm = ST_TEX;
      end
      ST_TEX: begin
        rz1 = {state_reg.refl[2] + FX_ONE, state_reg.refl[1:0]};
        // half of 1/m folded in with one shift
        sph = fx_rsqrt(fx_dot3(rz1, rz1)) >>> 1;
        for (int u = 0; u < NUM_UNITS; u++) begin
          for (int c = 0; c < 4; c++) begin
            state_next.tex_out[u][c] = state_reg.tex_in[u][c];
            if (state_reg.gen_en[u][c]) begin
              case (state_reg.func[u][c])
                GEN_OBJECT_LINEAR: state_next.tex_out[u][c] =
                  fx_dot4(state_reg.obj_plane[u][c], state_reg.vtx.obj);
                GEN_EYE_LINEAR: state_next.tex_out[u][c] =
                  fx_dot4(state_reg.eye_plane[u][c], state_reg.vtx.eye);
                GEN_SPHERICAL_ENV: begin
                  if (c < 2) begin
                    state_next.tex_out[u][c] = fx_mul(state_reg.refl[c], sph) + FX_HALF;
                  end
                end
                GEN_REFLECTION: begin
                  if (c < 3) begin
                    state_next.tex_out[u][c] = state_reg.refl[c];
                  end
                end
                GEN_NORMAL: begin
                  if (c < 3) begin
                    state_next.tex_out[u][c] = state_reg.nrm[c];
                  end
                end
                default: begin
                end
              endcase
            end
          end
        end
        state_next.fsm = ST_DONE;
      end
      ST_DONE: begin
        if (vout_ready) begin
          state_next.fsm = ST_IDLE;
        end
      end
      default: state_next.fsm = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = !state_reg.aw_held && !state_reg.bvalid;
  assign wready = !state_reg.w_held && !state_reg.bvalid;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = !state_reg.rvalid;
  assign rvalid = state_reg.rvalid;
  assign rresp = state_reg.rresp;
  assign rdata = state_reg.rdata;
  assign vin_ready = state_reg.fsm == ST_IDLE;
  assign vout_valid = state_reg.fsm == ST_DONE;
  assign vout_normal = state_reg.nrm;
  assign vout_tex = state_reg.tex_out;

endmodule : normal_xform_texcoord_gen

/* rtl/xform_gen_pkg.sv */
package xform_gen_pkg;

  // ----------------------------------------------------------------
  // number format: signed fixed point, 16 integer and 16 fraction bits
  // ----------------------------------------------------------------
  localparam int FX_FRAC = 16;
  typedef logic signed [31:0] fx_t;
  localparam fx_t FX_ZERO = 32'sh0000_0000;
  localparam fx_t FX_ONE = 32'sh0001_0000;
  localparam fx_t FX_HALF = 32'sh0000_8000;
  localparam logic [63:0] FX_RECIP_NUM = 64'h0000_0001_0000_0000;
  localparam logic [63:0] FX_SAT = 64'h0000_0000_7fff_ffff;

  typedef fx_t [3:0] vec4_t;
  typedef fx_t [2:0] vec3_t;
  // row index first, then column
  typedef fx_t [3:0][3:0] mat4_t;

  typedef struct packed {
    vec4_t obj;
    vec4_t eye;
    vec3_t normal;
  } vertex_in_t;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACTIVE_UNIT = 8'h04;
  localparam logic [7:0] OFS_GEN_ENABLE = 8'h08;
  localparam logic [7:0] OFS_PLANE0 = 8'h0c;
  localparam logic [7:0] OFS_PLANE1 = 8'h10;
  localparam logic [7:0] OFS_PLANE2 = 8'h14;
  localparam logic [7:0] OFS_PLANE3 = 8'h18;
  localparam logic [7:0] OFS_SETUP_CMD = 8'h1c;
  localparam logic [7:0] OFS_ERROR = 8'h20;
  localparam logic [7:0] OFS_FUNC_READ = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  localparam int CTRL_RESCALE_BIT = 0;
  localparam int CTRL_UNIT_LEN_BIT = 1;
  localparam int ERR_ENUM_BIT = 0;
  localparam int ERR_OP_BIT = 1;
  localparam int CMD_COORD_LSB = 0;
  localparam int CMD_PNAME_LSB = 2;
  localparam int CMD_FUNC_LSB = 4;
  localparam int FUNC_FIELD_W = 3;

  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // command encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] COORD_S = 2'h0;
  localparam logic [1:0] COORD_T = 2'h1;
  localparam logic [1:0] COORD_R = 2'h2;
  localparam logic [1:0] COORD_Q = 2'h3;

  localparam logic [1:0] PNAME_FUNC = 2'h0;
  localparam logic [1:0] PNAME_OBJ_PLANE = 2'h1;
  localparam logic [1:0] PNAME_EYE_PLANE = 2'h2;

  typedef enum logic [2:0] {
    GEN_OBJECT_LINEAR = 3'h0,
    GEN_EYE_LINEAR = 3'h1,
    GEN_SPHERICAL_ENV = 3'h2,
    GEN_REFLECTION = 3'h3,
    GEN_NORMAL = 3'h4
  } gen_func_t;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_XFORM = 7'h02,
    ST_RESCALE = 7'h04,
    ST_NORM = 7'h08,
    ST_REFL = 7'h10,
    ST_TEX = 7'h20,
    ST_DONE = 7'h40
  } fsm_t;

endpackage : xform_gen_pkg

/* dv/normal_xform_props.sv */
`timescale 1ns/1ns
module normal_xform_props
  import xform_gen_pkg::*;
#(
  parameter int NUM_UNITS = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // vertex stream
  input wire logic vin_valid,
  input wire logic vin_ready,
  input wire logic vout_valid,
  input wire logic vout_ready,
  input wire vec3_t vout_normal,
  input wire vec4_t [NUM_UNITS-1:0] vout_tex
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bvalid_hold_a:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rvalid_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped early");
  write_resp_a:
    assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  read_resp_a:
    assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  bus_block_a:
    assert property ((bvalid |-> !awready && !wready) and (rvalid |-> !arready))
    else $error("bus accepted while answer pending");
  reset_idle_a:
    assert property ($rose(aresetn) |-> vin_ready && !vout_valid && !bvalid && !rvalid)
    else $error("not idle after reset");
  vout_latency_a:
    assert property (vin_valid && vin_ready |=> !vout_valid [*5] ##1 vout_valid)
    else $error("result not after six cycles");
  busy_refuse_a:
    assert property (vin_valid && vin_ready |=> !vin_ready [*6])
    else $error("vertex taken while busy");
  vout_hold_a:
    assert property (vout_valid && !vout_ready |=>
      vout_valid && $stable(vout_tex) && $stable(vout_normal))
    else $error("result changed while stalled");
  vout_release_a:
    assert property (vout_valid && vout_ready |=> !vout_valid && vin_ready)
    else $error("result not released");
endmodule : normal_xform_props

bind normal_xform_texcoord_gen normal_xform_props #(.NUM_UNITS(NUM_UNITS)) u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .vin_valid(vin_valid), .vin_ready(vin_ready), .vout_valid(vout_valid),
  .vout_ready(vout_ready), .vout_normal(vout_normal), .vout_tex(vout_tex));

/* dv/vertex_pipe_model.sv */
`timescale 1ns/1ns
module vertex_pipe_model (
  // clock
  input wire logic aclk,
  // control from the bench
  input wire logic start,
  input wire logic [3:0] stall,
  // vertex handshake
  output logic vin_valid,
  input wire logic vin_ready,
  input wire logic vout_valid,
  output logic vout_ready
);
  logic [3:0] wait_cnt;
  initial begin
    vin_valid = 1'b0;
    vout_ready = 1'b0;
    wait_cnt = 4'h0;
  end
  always @(posedge aclk) begin
    if (start) begin
      vin_valid <= 1'b1;
    end else if (vin_valid && vin_ready) begin
      vin_valid <= 1'b0;
    end
    // downstream may stall; result is taken once per vertex
    if (vout_valid && !vout_ready) begin
      if (wait_cnt == stall) begin
        vout_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end else begin
      vout_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end
endmodule : vertex_pipe_model

/* dv/test_normal_xform_texcoord_gen.sv */
`timescale 1ns/1ns
module test_normal_xform_texcoord_gen;
  import xform_gen_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d, d0;
  logic [3:0] wstrb = 4'hf, stall = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, vin_ready, vout_valid;
  logic vin_valid, vout_ready, start = 1'b0;
  logic [1:0] bresp, rresp, r;
  mat4_t mv_inv, ident, m2;
  vertex_in_t vin = '0;
  vec4_t [1:0] vin_tex = '0, vout_tex, tex;
  vec3_t vout_normal, nrm;
  vec4_t p;
  logic [6:0] bad [6] = '{7'h22, 7'h23, 7'h33, 7'h43, 7'h50, 7'h0c};
  int n_errors = 0, checks_done = 0;

  always #5 aclk = ~aclk;

  normal_xform_texcoord_gen #(.NUM_UNITS(2), .ADDR_W(8)) u_normal_xform_texcoord_gen (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .mv_inv(mv_inv), .vin_valid(vin_valid), .vin_ready(vin_ready), .vin(vin),
    .vin_tex(vin_tex), .vout_valid(vout_valid), .vout_ready(vout_ready),
    .vout_normal(vout_normal), .vout_tex(vout_tex));

  vertex_pipe_model u_vertex_pipe_model (.aclk(aclk), .start(start), .stall(stall),
    .vin_valid(vin_valid), .vin_ready(vin_ready), .vout_valid(vout_valid),
    .vout_ready(vout_ready));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic fx_t rfx();
    return fx_t'($signed($urandom_range(0, 14)) - 7) <<< FX_FRAC;
  endfunction : rfx

  // integer-valued operands keep fixed point exact
  function automatic fx_t dot4(vec4_t a, vec4_t b);
    logic signed [63:0] acc;
    acc = 0;
    for (int i = 0; i < 4; i++) acc += (64'(a[i]) * 64'(b[i])) >>> FX_FRAC;
    return fx_t'(acc);
  endfunction : dot4

  // q term of the normal transform; zero for points at infinity
  function automatic fx_t q_of(vertex_in_t v);
    return v.obj[3] == FX_ZERO ? FX_ZERO : -dot4({FX_ZERO, v.normal}, v.obj);
  endfunction : q_of

  function automatic logic [31:0] cmd(logic [1:0] c, logic [1:0] pn, logic [2:0] f);
    return {25'h0, f, pn, c};
  endfunction : cmd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------
  // bus master
  // --------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic at, wt, bt;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    while (!bt) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic at, rt;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rt = 1'b0;
    while (!rt) begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd

  task automatic run_vertex();
    int n;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      vin.obj[i] <= rfx();
      vin.eye[i] <= rfx();
      vin_tex[0][i] <= rfx();
      vin_tex[1][i] <= rfx();
      if (i < 3) vin.normal[i] <= rfx();
    end
    stall <= 4'($urandom_range(0, 3));
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!vout_valid && n < 40);
    check(vout_valid, 1'b1);
    nrm = vout_normal;
    tex = vout_tex;
    while (vout_valid) @(negedge aclk);
  endtask : run_vertex

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    ident = '0;
    for (int i = 0; i < 4; i++) ident[i][i] = FX_ONE;
    mv_inv = ident;
    void'($urandom(45));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_FUNC_READ); check(d, 32'h249);
    rd(OFS_CTRL); check(d, 32'h0);
    rd(8'h3c); check({30'h0, r}, {30'h0, AXI_SLVERR});
    wr(8'h3c, 32'h3);
    check({30'h0, r}, {30'h0, AXI_SLVERR});
    wr(OFS_CTRL, 32'h3); rd(OFS_CTRL); check(d, 32'h3);
    wr(OFS_CTRL, 32'h0);
    check({30'h0, r}, {30'h0, AXI_OKAY});
    run_vertex();
    for (int i = 0; i < 3; i++) check(nrm[i], vin.normal[i]);
    for (int i = 0; i < 8; i++) check(tex[i/4][i%4], vin_tex[i/4][i%4]);
    wr(OFS_GEN_ENABLE, 32'hf);
    run_vertex();
    check(tex[0][0], vin.eye[0]);
    check(tex[0][1], vin.eye[1]);
    check(tex[0][2] | tex[0][3], 32'h0);
    check(tex[1][0], vin_tex[1][0]);
    for (int i = 0; i < 4; i++) begin
      p[i] = rfx();
      wr(OFS_PLANE0 + 8'(4 * i), p[i]);
    end
    wr(OFS_SETUP_CMD, cmd(COORD_T, PNAME_OBJ_PLANE, 3'h0));
    wr(OFS_SETUP_CMD, cmd(COORD_T, PNAME_FUNC, GEN_OBJECT_LINEAR));
    mv_inv <= ident <<< 1;
    wr(OFS_SETUP_CMD, cmd(COORD_R, PNAME_EYE_PLANE, 3'h0));
    mv_inv <= ident;
    run_vertex();
    check(tex[0][1], dot4(p, vin.obj));
    check(tex[0][0], vin.eye[0]);
    check(tex[0][2], dot4(p, vin.eye) <<< 1);
    wr(OFS_SETUP_CMD, cmd(COORD_S, PNAME_FUNC, GEN_NORMAL));
    run_vertex();
    check(tex[0][0], vin.normal[0]);
    for (int f = 0; f < 5; f++) begin
      wr(OFS_SETUP_CMD, cmd(COORD_S, PNAME_FUNC, 3'(f)));
      rd(OFS_FUNC_READ); check({29'h0, d[2:0]}, 32'(f));
    end
    for (int i = 0; i < 6; i++) begin
      rd(OFS_FUNC_READ);
      d0 = d;
      wr(OFS_SETUP_CMD, {25'h0, bad[i]});
      rd(OFS_ERROR); check(d, 32'h1);
      rd(OFS_FUNC_READ); check(d, d0);
      wr(OFS_ERROR, 32'h1);
    end
    wr(OFS_ACTIVE_UNIT, 32'h2);
    wr(OFS_SETUP_CMD, cmd(COORD_S, PNAME_FUNC, GEN_OBJECT_LINEAR));
    rd(OFS_ERROR); check(d, 32'h2);
    wr(OFS_ERROR, 32'h3);
    wr(OFS_ACTIVE_UNIT, 32'h1);
    rd(OFS_FUNC_READ); check(d, 32'h249);
    // doubled matrix with a q row entry: rescale must halve it back
    m2 = ident <<< 1;
    m2[3][0] = 32'sh0002_0000;
    mv_inv <= m2;
    wr(OFS_CTRL, 32'h1);
    run_vertex();
    check(nrm[0], vin.normal[0] + q_of(vin));
    check(nrm[1], vin.normal[1]);
    check(nrm[2], vin.normal[2]);
    give_verdict();
  end
endmodule : test_normal_xform_texcoord_gen
